//--- rtl/igx_top.v
// eight-pin gpio expander behind a single-register i2c target
//
// Notes on behaviour
// [R01] single-register transfers only, no bursts
// [R02] bare read returns current pointer register
// [R03] address 1000011 or 1000100 by select pin
// [R04] rw bit 1 reads; ack pulls sda low
// [R05] soft reset bit restores defaults, reads 0
// [R06] reset flag set by reset, read clears
// [R07] fixed maker and revision fields read-only
// [R08] direction bit: 0 input, 1 output
// [R09] output level bit drives pin level
// [R10] float bit releases an output pin
// [R11] input pins ignore level and float
// [R12] output pins ignore compare, bias, mask, flag
// [R13] expected level picks which change flags
// [R14] bias enable switches resistor on
// [R15] bias direction: 0 down, 1 up
// [R16] live input register reads pins unlatched
// [R17] mask 0 passes event, 1 suppresses
// [R18] flag set when input leaves expected
// [R19] reading flags register clears them
// [R20] no new flag until input returns
// [R21] controller avoids reserved even addresses
// [R22] interrupt held until serviced
// [R23] every reset source restores defaults
// [R24] reset pin low resets device
// [R25] interrupt from unmasked flags or reset flag
`timescale 1ns/100ps
`include "igx_defines.vh"
module igx_top #(
  // arbitrary identity values
  parameter [2:0] MAKER_CODE = 3'h2,
  parameter [2:0] REVISION = 3'h1
) (
  input wire mclk_i,
  input wire rst_i,
  input wire ce_i,
  input wire rst_pin_n_i,
  input wire addr_sel_i,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  input wire [7:0] gpio_i,
  output wire [7:0] gpio_o,
  output wire [7:0] gpio_oe_o,
  output wire [7:0] pull_en_o,
  output wire [7:0] pull_up_o,
  output wire int_n_o,
  output wire int_oe_o
);
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_AACK = 4'h2;
  localparam [3:0] ST_PTR = 4'h3;
  localparam [3:0] ST_PACK = 4'h4;
  localparam [3:0] ST_WDAT = 4'h5;
  localparam [3:0] ST_WACK = 4'h6;
  localparam [3:0] ST_RDAT = 4'h7;
  localparam [3:0] ST_RACK = 4'h8;
  localparam [3:0] ST_SKIP = 4'h9;

  wire [11:0] sync_s;
  wire rst_pin_n_s;
  wire addr_sel_s;
  wire scl_s;
  wire sda_s;
  wire [7:0] gpio_s;
  wire hard_rst;
  wire reg_rst;
  wire [6:0] my_addr;
  wire start_det;
  wire stop_det;
  wire scl_rise;
  wire scl_fall;
  wire [7:0] flags;
  wire [7:0] irqs;

  reg scl_p_q;
  reg sda_p_q;
  reg [3:0] state_q;
  reg [2:0] cnt_q;
  reg done_q;
  reg [7:0] sh_q;
  reg [7:0] tx_q;
  reg rw_q;
  reg sda_low_q;
  reg [7:0] ptr_q;
  reg wr_q;
  reg [7:0] wdata_q;
  reg rd_q;
  reg [7:0] rdata;

  reg soft_q;
  reg rst_flag_q;
  reg [7:0] dir_q;
  reg [7:0] out_q;
  reg [7:0] float_q;
  reg [7:0] expect_q;
  reg [7:0] bias_en_q;
  reg [7:0] bias_dir_q;
  reg [7:0] mask_q;
  reg int_q;

  igx_sync #(
    .WIDTH(12),
    // bus and reset pins idle high; gpio stages start low so release flags no false change
    .RST_VAL(12'hF00)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({rst_pin_n_i, addr_sel_i, scl_i, sda_i, gpio_i}),
    .q_o(sync_s)
  );
  assign rst_pin_n_s = sync_s[11];
  assign addr_sel_s = sync_s[10];
  assign scl_s = sync_s[9];
  assign sda_s = sync_s[8];
  assign gpio_s = sync_s[7:0];

  // [R24] reset pin acts as a reset
  assign hard_rst = rst_i | ~rst_pin_n_s;
  // [R23] all sources restore register defaults
  assign reg_rst = hard_rst | soft_q;

  // [R03] select-pin address choice
  assign my_addr = addr_sel_s ? `IGX_TGT_ADDR_HI : `IGX_TGT_ADDR_LO;

  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;

  // [R04] acknowledge pulls low, release reads high
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_low_q;

  // [R02] read data from current pointer
  always @* begin
    case (ptr_q)
      // [R07] fixed identity fields
      `IGX_REG_CTRL: rdata = {MAKER_CODE, REVISION, rst_flag_q, soft_q};
      `IGX_REG_DIR: rdata = dir_q;
      `IGX_REG_OUT: rdata = out_q;
      `IGX_REG_FLOAT: rdata = float_q;
      `IGX_REG_EXPECT: rdata = expect_q;
      `IGX_REG_BIAS_EN: rdata = bias_en_q;
      `IGX_REG_BIAS_DIR: rdata = bias_dir_q;
      // [R16] live pin level
      `IGX_REG_LIVE: rdata = gpio_s;
      `IGX_REG_MASK: rdata = mask_q;
      `IGX_REG_FLAGS: rdata = flags;
      default: rdata = `IGX_UNMAPPED_RD;
    endcase
  end

  // target sequencer; the pointer survives a soft reset so a read can follow it
  always @(posedge mclk_i) begin
    if (hard_rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      done_q <= 1'b0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      sda_low_q <= 1'b0;
      ptr_q <= `IGX_RST_PTR;
      wr_q <= 1'b0;
      wdata_q <= 8'h00;
      rd_q <= 1'b0;
    end else if (ce_i) begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      if (start_det) begin
        state_q <= ST_ADDR;
        cnt_q <= 3'h0;
        done_q <= 1'b0;
        sda_low_q <= 1'b0;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        sda_low_q <= 1'b0;
      end else if (scl_rise) begin
        case (state_q)
          ST_ADDR, ST_PTR, ST_WDAT: begin
            sh_q <= {sh_q[6:0], sda_s};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7)
              done_q <= 1'b1;
          end
          ST_RDAT: begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7)
              done_q <= 1'b1;
          end
          default: begin
            done_q <= done_q;
          end
        endcase
      end else if (scl_fall) begin
        case (state_q)
          ST_ADDR: begin
            if (done_q) begin
              done_q <= 1'b0;
              // [R03] match seven-bit address
              if (sh_q[7:1] == my_addr) begin
                rw_q <= sh_q[0];
                sda_low_q <= 1'b1;
                state_q <= ST_AACK;
              end else begin
                state_q <= ST_SKIP;
              end
            end
          end
          ST_AACK: begin
            cnt_q <= 3'h0;
            // [R04] rw bit picks direction
            if (rw_q) begin
              // [R02] read without pointer write
              state_q <= ST_RDAT;
              sda_low_q <= ~rdata[7];
              tx_q <= {rdata[6:0], 1'b0};
              rd_q <= 1'b1;
            end else begin
              state_q <= ST_PTR;
              sda_low_q <= 1'b0;
            end
          end
          ST_PTR: begin
            if (done_q) begin
              done_q <= 1'b0;
              ptr_q <= sh_q;
              sda_low_q <= 1'b1;
              state_q <= ST_PACK;
            end
          end
          ST_PACK: begin
            cnt_q <= 3'h0;
            sda_low_q <= 1'b0;
            state_q <= ST_WDAT;
          end
          ST_WDAT: begin
            if (done_q) begin
              done_q <= 1'b0;
              wr_q <= 1'b1;
              wdata_q <= sh_q;
              sda_low_q <= 1'b1;
              state_q <= ST_WACK;
            end
          end
          ST_WACK: begin
            // [R01] further bytes left unacknowledged
            sda_low_q <= 1'b0;
            state_q <= ST_SKIP;
          end
          ST_RDAT: begin
            if (done_q) begin
              done_q <= 1'b0;
              sda_low_q <= 1'b0;
              state_q <= ST_RACK;
            end else begin
              sda_low_q <= ~tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
          ST_RACK: begin
            // [R01] no burst read, released until stop
            sda_low_q <= 1'b0;
            state_q <= ST_SKIP;
          end
          default: begin
            sda_low_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // configuration registers; reserved addresses swallow writes
  always @(posedge mclk_i) begin
    if (reg_rst) begin
      // [R05] defaults restored, soft bit back to 0
      soft_q <= 1'b0;
      // [R06] any reset raises flag
      rst_flag_q <= 1'b1;
      dir_q <= `IGX_RST_DIR;
      out_q <= `IGX_RST_OUT;
      float_q <= `IGX_RST_FLOAT;
      expect_q <= `IGX_RST_EXPECT;
      bias_en_q <= `IGX_RST_BIAS_EN;
      bias_dir_q <= `IGX_RST_BIAS_DIR;
      mask_q <= `IGX_RST_MASK;
    end else if (ce_i) begin
      // [R06] read clears reset flag
      if (rd_q && ptr_q == `IGX_REG_CTRL)
        rst_flag_q <= 1'b0;
      if (wr_q) begin
        case (ptr_q)
          // [R05] soft reset request
          `IGX_REG_CTRL: soft_q <= wdata_q[`IGX_CTRL_SOFT_RST];
          `IGX_REG_DIR: dir_q <= wdata_q;
          `IGX_REG_OUT: out_q <= wdata_q;
          `IGX_REG_FLOAT: float_q <= wdata_q;
          // [R13] expected input level
          `IGX_REG_EXPECT: expect_q <= wdata_q;
          `IGX_REG_BIAS_EN: bias_en_q <= wdata_q;
          `IGX_REG_BIAS_DIR: bias_dir_q <= wdata_q;
          `IGX_REG_MASK: mask_q <= wdata_q;
          default: soft_q <= soft_q;
        endcase
      end
    end
  end

  genvar p;
  generate
    for (p = 0; p < 8; p = p + 1) begin : g_pin
      igx_pin_cell u_pin (
        .mclk_i(mclk_i),
        .rst_i(reg_rst),
        .ce_i(ce_i),
        .dir_i(dir_q[p]),
        .out_lvl_i(out_q[p]),
        .float_i(float_q[p]),
        .expect_i(expect_q[p]),
        .bias_en_i(bias_en_q[p]),
        .bias_dir_i(bias_dir_q[p]),
        .mask_i(mask_q[p]),
        .pin_i(gpio_s[p]),
        .clr_i(rd_q && ptr_q == `IGX_REG_FLAGS),
        .pin_o(gpio_o[p]),
        .pin_oe_o(gpio_oe_o[p]),
        .bias_en_o(pull_en_o[p]),
        .bias_up_o(pull_up_o[p]),
        .flag_o(flags[p]),
        .irq_o(irqs[p])
      );
    end
  endgenerate

  // level interrupt; a read clears the cause, not the pin directly
  always @(posedge mclk_i) begin
    if (hard_rst) begin
      int_q <= 1'b0;
    end else if (ce_i) begin
      // [R25] unmasked flags or reset flag
      // [R22] held until serviced
      int_q <= (|irqs) | rst_flag_q;
    end
  end
  assign int_n_o = 1'b0;
  assign int_oe_o = int_q;
endmodule // igx_top

//--- rtl/igx_defines.vh
// register map, field layout, reset values and addresses of the gpio expander
`ifndef IGX_DEFINES_VH
`define IGX_DEFINES_VH
`define IGX_TGT_ADDR_LO 7'h43
`define IGX_TGT_ADDR_HI 7'h44
`define IGX_REG_CTRL 8'h01
`define IGX_REG_DIR 8'h03
`define IGX_REG_OUT 8'h05
`define IGX_REG_FLOAT 8'h07
`define IGX_REG_EXPECT 8'h09
`define IGX_REG_BIAS_EN 8'h0B
`define IGX_REG_BIAS_DIR 8'h0D
`define IGX_REG_LIVE 8'h0F
`define IGX_REG_MASK 8'h11
`define IGX_REG_FLAGS 8'h13
`define IGX_CTRL_SOFT_RST 0
`define IGX_CTRL_RST_FLAG 1
`define IGX_RST_DIR 8'h00
`define IGX_RST_OUT 8'h00
`define IGX_RST_FLOAT 8'hFF
`define IGX_RST_EXPECT 8'h00
`define IGX_RST_BIAS_EN 8'hFF
`define IGX_RST_BIAS_DIR 8'h00
`define IGX_RST_MASK 8'h00
`define IGX_RST_PTR 8'h00
`define IGX_UNMAPPED_RD 8'h00
`endif

//--- rtl/igx_sync.v
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module igx_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
  input wire mclk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge mclk_i) begin
        if (rst_i) begin
          meta_q[i] <= RST_VAL[i];
          sync_q[i] <= RST_VAL[i];
        end else if (ce_i) begin
          meta_q[i] <= d_i[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
  assign q_o = sync_q;
endmodule // igx_sync

//--- rtl/igx_pin_cell.v
// one gpio pin: drive control, bias control and change-event flag
`timescale 1ns/100ps
module igx_pin_cell (
  input wire mclk_i,
  input wire rst_i,
  input wire ce_i,
  input wire dir_i,
  input wire out_lvl_i,
  input wire float_i,
  input wire expect_i,
  input wire bias_en_i,
  input wire bias_dir_i,
  input wire mask_i,
  input wire pin_i,
  input wire clr_i,
  output reg pin_o,
  output reg pin_oe_o,
  output reg bias_en_o,
  output reg bias_up_o,
  output wire flag_o,
  output wire irq_o
);
  reg flag_q;
  reg seen_q;
  wire differ;
  // [R12] outputs ignore compare
  assign differ = ~dir_i & (pin_i ^ expect_i);
  always @(posedge mclk_i) begin
    if (rst_i) begin
      pin_o <= 1'b0;
      pin_oe_o <= 1'b0;
      bias_en_o <= 1'b0;
      bias_up_o <= 1'b0;
      flag_q <= 1'b0;
      seen_q <= 1'b0;
    end else if (ce_i) begin
      // [R08] direction selects drive
      // [R09] level follows register
      pin_o <= out_lvl_i;
      // [R10] float overrides level; [R11] inputs never driven
      pin_oe_o <= dir_i & ~float_i;
      // [R14] bias enable
      bias_en_o <= ~dir_i & bias_en_i;
      // [R15] pull direction
      bias_up_o <= ~dir_i & bias_en_i & bias_dir_i;
      // [R20] rearm on return
      if (!differ)
        seen_q <= 1'b0;
      else
        seen_q <= 1'b1;
      // [R18] flag on mismatch; set beats read-clear
      if (differ && !seen_q)
        flag_q <= 1'b1;
      // [R19] read clears flag
      else if (clr_i)
        flag_q <= 1'b0;
    end
  end
  assign flag_o = flag_q;
  // [R17] mask gates event
  assign irq_o = flag_q & ~mask_i & ~dir_i;
endmodule // igx_pin_cell

//--- verification/igx_top_checker.sv
// concurrent checks on the expander's pins
`timescale 1ns/100ps
module igx_top_checker (
  input wire mclk_i,
  input wire rst_i,
  input wire rst_pin_n_i,
  input wire scl_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire [7:0] gpio_oe_o,
  input wire [7:0] pull_en_o,
  input wire [7:0] pull_up_o,
  input wire int_n_o,
  input wire int_oe_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence pin_low;
    !rst_pin_n_i [*3];
  endsequence
  sequence rst_done;
    int_oe_o && gpio_oe_o == 8'h00 && pull_en_o == 8'hFF;
  endsequence
  a_sda_open_drain: assert property (sda_o == 1'b0)
    else $error("sda output not held low");
  a_int_open_drain: assert property (int_n_o == 1'b0)
    else $error("interrupt output not held low");
  // the ack bit only moves while scl is low, so the controller samples a steady level
  a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("sda drive changed while scl high");
  a_int_held_fall: assert property ($fell(int_oe_o) && rst_pin_n_i |-> !scl_i)
    else $error("interrupt dropped outside a bus access");
  a_rst_release: assert property ($fell(rst_i) |-> ##[1:3] rst_done)
    else $error("defaults missing after reset");
  a_pin_reset: assert property (pin_low |-> ##[0:4] (gpio_oe_o == 8'h00 && !int_oe_o))
    else $error("reset pin did not reset");
  a_pin_release: assert property ($rose(rst_pin_n_i) |-> ##[1:6] rst_done)
    else $error("defaults missing after reset pin");
  a_pull_inputs_only: assert property ((pull_en_o & gpio_oe_o) == 8'h00)
    else $error("bias on a driven pin");
  a_pull_up_gated: assert property ((pull_up_o & ~pull_en_o) == 8'h00)
    else $error("pull-up without bias enable");
endmodule // igx_top_checker

//--- verification/igx_ctl_model.sv
// i2c controller model driving the expander's bus pins
`timescale 1ns/100ps
module igx_ctl_model (
  input wire mclk_i,
  input wire sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic hp();
    repeat (8) @(posedge mclk_i);
  endtask
  // data moves only while scl is low; sampled at the end of scl high
  task automatic bx(input logic b, output logic s);
    sda_low_o <= !b;
    hp();
    scl_o <= 1'b1;
    hp();
    s = sda_i;
    scl_o <= 1'b0;
  endtask
  // msb first, ack seen as sda low
  task automatic bo(input logic [7:0] d, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) bx(d[i], s);
    bx(1'b1, s);
    a = !s;
  endtask
  task automatic st();
    sda_low_o <= 1'b0;
    hp();
    scl_o <= 1'b1;
    hp();
    sda_low_o <= 1'b1;
    hp();
    scl_o <= 1'b0;
  endtask
  task automatic sp();
    sda_low_o <= 1'b1;
    hp();
    scl_o <= 1'b1;
    hp();
    sda_low_o <= 1'b0;
    hp();
  endtask
  // address plus write flag, any pointer, then min(nb, 2) data bytes: d, then ~d
  task automatic wr(input logic [6:0] t, input logic [7:0] p, input logic [7:0] d,
      input int nb, output logic [3:0] ak);
    st();
    bo({t, 1'b0}, ak[0]);
    bo(p, ak[1]);
    ak[3:2] = 2'b00;
    if (nb > 0) bo(d, ak[2]);
    if (nb > 1) bo(~d, ak[3]);
    sp();
  endtask
  // read flag 1, one byte then a not-acknowledge
  task automatic rd(input logic [6:0] t, output logic [7:0] d, output logic a);
    logic s;
    st();
    bo({t, 1'b1}, a);
    for (int i = 7; i >= 0; i--) begin
      bx(1'b1, s);
      d[i] = s;
    end
    bx(1'b1, s);
    sp();
  endtask
endmodule // igx_ctl_model

//--- verification/test_igx_top.sv
// self-checking bench for the gpio expander
`timescale 1ns/100ps
`include "igx_defines.vh"
module test_igx_top;
  localparam logic [2:0] MK = 3'h2;
  localparam logic [2:0] RV = 3'h1;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rst_pin_n_i = 1'b1;
  logic addr_sel_i = 1'b0;
  logic [7:0] gpio_i = 8'h00;
  logic sda_o, sda_oe_o, int_n_o, int_oe_o, scl, sda_low;
  logic [7:0] gpio_o, gpio_oe_o, pull_en_o, pull_up_o, v;
  logic [3:0] ak;
  logic [7:0] ra [7] = '{`IGX_REG_DIR, `IGX_REG_OUT, `IGX_REG_FLOAT, `IGX_REG_EXPECT,
      `IGX_REG_BIAS_EN, `IGX_REG_BIAS_DIR, `IGX_REG_MASK};
  logic [7:0] rv [7] = '{`IGX_RST_DIR, `IGX_RST_OUT, `IGX_RST_FLOAT, `IGX_RST_EXPECT,
      `IGX_RST_BIAS_EN, `IGX_RST_BIAS_DIR, `IGX_RST_MASK};
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  // open-drain sda with pull-up
  wire sda_w = !(sda_oe_o || sda_low);
  initial forever #2 mclk_i = !mclk_i;
  igx_top #(.MAKER_CODE(MK), .REVISION(RV)) igx_top_i (.mclk_i(mclk_i), .rst_i(rst_i),
      .ce_i(1'b1), .rst_pin_n_i(rst_pin_n_i), .addr_sel_i(addr_sel_i), .scl_i(scl),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .gpio_i(gpio_i), .gpio_o(gpio_o),
      .gpio_oe_o(gpio_oe_o), .pull_en_o(pull_en_o), .pull_up_o(pull_up_o),
      .int_n_o(int_n_o), .int_oe_o(int_oe_o));
  igx_ctl_model igx_ctl_model_i (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl),
      .sda_low_o(sda_low));
  task automatic results();
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    igx_ctl_model_i.wr(7'h43, a, d, 1, ak);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    igx_ctl_model_i.wr(7'h43, a, 8'h00, 0, ak);
    igx_ctl_model_i.rd(7'h43, v, ak[0]);
    chk($sformatf("reg %h", a), v, e);
  endtask
  task automatic irq(input logic e);
    repeat (8) @(posedge mclk_i);
    chk("irq", {7'h00, int_oe_o}, {7'h00, e});
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    irq(1'b1); // reset flag
    igx_ctl_model_i.rd(7'h43, v, ak[0]);
    chk("bare", v, `IGX_UNMAPPED_RD); // pointer zero
    rreg(`IGX_REG_CTRL, {MK, RV, 2'b10}); // identity
    igx_ctl_model_i.rd(7'h43, v, ak[0]);
    chk("bare", v, {MK, RV, 2'b00}); // flag cleared
    irq(1'b0); // serviced
    rreg(8'h02, `IGX_UNMAPPED_RD); // reserved
    for (int i = 0; i < 7; i++) rreg(ra[i], rv[i]); // defaults
    wreg(`IGX_REG_CTRL, 8'hFC);
    rreg(`IGX_REG_CTRL, {MK, RV, 2'b00}); // read-only
    addr_sel_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    igx_ctl_model_i.wr(7'h43, `IGX_REG_DIR, 8'hFF, 1, ak);
    chk("low addr", {4'h0, ak}, 8'h00); // ignored
    igx_ctl_model_i.wr(7'h44, `IGX_REG_DIR, 8'hFF, 2, ak);
    chk("burst", {4'h0, ak}, 8'h07); // second byte refused
    addr_sel_i <= 1'b0;
    wreg(`IGX_REG_OUT, 8'h5A);
    wreg(`IGX_REG_FLOAT, 8'h0F);
    chk("oe", gpio_oe_o, 8'hF0); // drive
    chk("out", gpio_o, 8'h5A); // level
    chk("pull", pull_en_o, 8'h00); // outputs
    wreg(`IGX_REG_DIR, 8'h3C);
    chk("oe", gpio_oe_o, 8'h30); // inputs float
    chk("pull", pull_en_o, 8'hC3); // inputs biased
    wreg(`IGX_REG_BIAS_DIR, 8'h81);
    chk("up", pull_up_o, 8'h81); // pull-up
    wreg(`IGX_REG_BIAS_EN, 8'h80);
    chk("pull", pull_en_o, 8'h80); // off
    chk("up", pull_up_o, 8'h80); // gated
    wreg(`IGX_REG_DIR, 8'h00);
    wreg(`IGX_REG_EXPECT, 8'h01);
    irq(1'b1); // pin low
    rreg(`IGX_REG_FLAGS, 8'h01); // flagged
    rreg(`IGX_REG_FLAGS, 8'h00); // no repeat
    irq(1'b0); // cleared
    wreg(`IGX_REG_MASK, 8'h02);
    gpio_i <= 8'h03;
    irq(1'b0); // masked
    rreg(`IGX_REG_FLAGS, 8'h02); // rising
    gpio_i <= 8'h02;
    irq(1'b1); // left again
    rreg(`IGX_REG_LIVE, 8'h02); // live
    rreg(`IGX_REG_FLAGS, 8'h01); // flagged again
    gpio_i <= 8'h96;
    rreg(`IGX_REG_LIVE, 8'h96); // unlatched
    rreg(`IGX_REG_FLAGS, 8'h94); // new leavers
    wreg(`IGX_REG_DIR, 8'hFF);
    gpio_i <= 8'h61;
    rreg(`IGX_REG_FLAGS, 8'h00); // outputs ignored
    wreg(`IGX_REG_CTRL, 8'h01);
    rreg(`IGX_REG_CTRL, {MK, RV, 2'b10}); // soft reset
    rreg(`IGX_REG_DIR, `IGX_RST_DIR); // soft reset
    wreg(`IGX_REG_OUT, 8'h33);
    rst_pin_n_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    rst_pin_n_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    rreg(`IGX_REG_OUT, `IGX_RST_OUT); // pin reset
    rreg(`IGX_REG_CTRL, {MK, RV, 2'b10}); // flag set
    results();
  end
endmodule // test_igx_top
bind igx_top igx_top_checker igx_top_checker_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .rst_pin_n_i(rst_pin_n_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .gpio_oe_o(gpio_oe_o), .pull_en_o(pull_en_o), .pull_up_o(pull_up_o),
    .int_n_o(int_n_o), .int_oe_o(int_oe_o));
